//--- rtl/ldps_consts.svh
`ifndef LDPS_CONSTS_SVH
`define LDPS_CONSTS_SVH

// Core clock period
`define LDPS_CLK_PERIOD_NS   5
// Enable input held low this long puts the block to sleep
`define LDPS_SHUTDOWN_NS     16000000
`define LDPS_SHUTDOWN_CYC    (`LDPS_SHUTDOWN_NS / `LDPS_CLK_PERIOD_NS)
// No dimming clock edge for this long leaves clocked mode
`define LDPS_FALLBACK_NS     50000
`define LDPS_FALLBACK_CYC    (`LDPS_FALLBACK_NS / `LDPS_CLK_PERIOD_NS)
// Time between single steps of the current level ramp
`define LDPS_SLEW_NS         4000
`define LDPS_SLEW_CYC        (`LDPS_SLEW_NS / `LDPS_CLK_PERIOD_NS)
// Level codes: full scale and the minimum floor of about 10 percent
`define LDPS_LVL_FULL        8'hFF
`define LDPS_LVL_MIN         8'h1A
// Reset values
`define LDPS_LVL_RESET       8'h1A

`endif

//--- rtl/ldps_pkg.sv
package ldps_pkg;

    // Dimming sequencer states
    typedef enum logic [2:0] {
        LDPS_OFF,
        LDPS_PRE,
        LDPS_ON,
        LDPS_POST,
        LDPS_SLEEP
    } ldps_seq_state_type;

    // Analog dimming source
    typedef enum logic {
        LDPS_MODE_VOLTAGE,
        LDPS_MODE_CLOCKED
    } ldps_dim_mode_type;

endpackage : ldps_pkg

//--- rtl/ldps_dim_if.sv
interface ldps_dim_if;
    import ldps_pkg::*;

    logic              clk_level;
    ldps_dim_mode_type mode;
    logic [7:0]        meas_level;

    modport meter (
        input  clk_level,
        output mode,
        output meas_level
    );

    modport seq (
        output clk_level,
        input  mode,
        input  meas_level
    );
endinterface : ldps_dim_if

//--- rtl/ldps_duty_meter.sv
`include "ldps_consts.svh"

module ldps_duty_meter
    import ldps_pkg::*;
#(
    parameter int FALLBACK_CYC = `LDPS_FALLBACK_CYC
) (
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic reset_i,
    // Dimming clock measurement
    ldps_dim_if.meter dim
);

    localparam int IW = $clog2(FALLBACK_CYC + 1);

    typedef struct packed {
        logic              prev;
        logic              seen_fall;
        logic [15:0]       hi_cnt;
        logic [15:0]       lo_cnt;
        logic [IW-1:0]     idle_cnt;
        ldps_dim_mode_type mode;
        logic              busy;
        logic [3:0]        step;
        logic [16:0]       rem;
        logic [16:0]       den;
        logic [7:0]        quo;
        logic [7:0]        level;
    } ldps_meter_reg_type;

    ldps_meter_reg_type r_q;
    ldps_meter_reg_type r_d;

    always_comb begin
        logic [17:0] dbl;
        dbl = '0;
        r_d = r_q;
        r_d.prev = dim.clk_level;
        if (r_q.idle_cnt != IW'(FALLBACK_CYC)) begin
            r_d.idle_cnt = r_q.idle_cnt + IW'(1);
        end
        // RQ8 clock loss fallback
        if (r_q.idle_cnt == IW'(FALLBACK_CYC)) begin
            r_d.mode      = LDPS_MODE_VOLTAGE;
            r_d.seen_fall = 1'b0;
        end
        // Saturating high and low time counters
        if (dim.clk_level && r_q.hi_cnt != 16'hFFFF) begin
            r_d.hi_cnt = r_q.hi_cnt + 16'h0001;
        end
        if (!dim.clk_level && r_q.lo_cnt != 16'hFFFF) begin
            r_d.lo_cnt = r_q.lo_cnt + 16'h0001;
        end
        if (dim.clk_level != r_q.prev) begin
            r_d.idle_cnt = '0;
        end
        if (!dim.clk_level && r_q.prev) begin
            r_d.seen_fall = 1'b1;
        end
        // RQ15 period complete
        if (dim.clk_level && !r_q.prev) begin
            r_d.hi_cnt = 16'h0001;
            r_d.lo_cnt = 16'h0000;
            if (r_q.seen_fall && r_q.hi_cnt != 16'h0000) begin
                // RQ6 clock detected
                r_d.mode = LDPS_MODE_CLOCKED;
                r_d.busy = 1'b1;
                r_d.step = 4'h0;
                r_d.rem  = {1'b0, r_q.lo_cnt};
                r_d.den  = {1'b0, r_q.hi_cnt} + {1'b0, r_q.lo_cnt};
                r_d.quo  = 8'h00;
            end
        end else if (r_q.busy) begin
            // RQ7 low fraction is the level
            dbl = {r_q.rem, 1'b0};
            if (dbl >= {1'b0, r_q.den}) begin
                r_d.rem = 17'(dbl - {1'b0, r_q.den});
                r_d.quo = {r_q.quo[6:0], 1'b1};
            end else begin
                r_d.rem = 17'(dbl);
                r_d.quo = {r_q.quo[6:0], 1'b0};
            end
            r_d.step = r_q.step + 4'h1;
            if (r_q.step == 4'h7) begin
                r_d.busy  = 1'b0;
                r_d.level = r_d.quo;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            r_q       <= '0;
            r_q.mode  <= LDPS_MODE_VOLTAGE;
            r_q.level <= `LDPS_LVL_FULL;
        end else begin
            r_q <= r_d;
        end
    end

    assign dim.mode       = r_q.mode;
    assign dim.meas_level = r_q.level;

endmodule : ldps_duty_meter

//--- rtl/ldps_top.sv
// Overview of operation
// RQ1 - PWM rise starts boost now, sinks after the pre-boost time.
// RQ2 - PWM fall keeps boost and sinks on for the same pre-boost time. After a pulse shorter than that time, sinks light only for the pulse width.
// RQ3 - Pre-boost time comes from the external setting, same for both edges.
// RQ4 - Integrator starts near 2.5 to 4 us at 2 MHz, then tunes.
// RQ5 - Current level scales from about 10 to 100 percent.
// RQ6 - A toggling dimming clock selects clocked dimming mode.
// RQ7 - Clocked mode level is 100 percent minus clock high duty.
// RQ8 - No clock pulse for about 50 us returns to voltage mode.
// RQ9 - Host keeps dimming clock high and low times at least 150 ns.
// RQ10 - Host runs the dimming clock between 40 kHz and 1 MHz.
// RQ11 - Undriven analog dimming input gives the minimum 10 percent level.
// RQ12 - Sinks on while enable input high, off while low.
// RQ13 - Enable low beyond about 16 ms shuts the block down.
// RQ14 - Host never drives enable low pulses shorter than 1 us.
// RQ15 - Duty measured each full period; level ramps toward the result.
// RQ16 - Every dimming edge restarts a full pre-boost delay.
`include "ldps_consts.svh"

module ldps_top
    import ldps_pkg::*;
#(
    parameter int TW           = 10,
    parameter int SHUTDOWN_CYC = `LDPS_SHUTDOWN_CYC,
    parameter int FALLBACK_CYC = `LDPS_FALLBACK_CYC
) (
    // Clock and reset
    input  wire logic          mclk_i,
    input  wire logic          reset_i,
    // Dimming pins
    input  wire logic          pwm_i,
    input  wire logic          analog_dim_input_i,
    // Settings from the analog front end
    input  wire logic [TW-1:0] pre_boost_time_i,
    input  wire logic [7:0]    voltage_level_i,
    // Converter control
    output logic               boost_en_o,
    output logic               sink_en_o,
    output logic               shutdown_o,
    // Dimming status and level
    output logic               clocked_dim_mode_o,
    output logic [7:0]         current_level_o
);

    localparam int SW = $clog2(SHUTDOWN_CYC + 1);
    localparam int LW = $clog2(`LDPS_SLEW_CYC + 1);

    typedef struct packed {
        logic [1:0]         pwm_sync;
        logic [1:0]         dim_sync;
        logic               pwm_prev;
        ldps_seq_state_type state;
        logic [TW-1:0]      timer;
        logic [TW-1:0]      gate;
        logic [SW-1:0]      off_cnt;
        logic [LW-1:0]      slew_cnt;
        logic [7:0]         level;
        logic               boost;
        logic               sink;
        logic               sleep;
    } ldps_top_reg_type;

    ldps_top_reg_type r_q;
    ldps_top_reg_type r_d;

    ldps_dim_if dim ();

    ldps_duty_meter #(
        .FALLBACK_CYC (FALLBACK_CYC)
    ) u_meter (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .dim     (dim.meter)
    );

    // Only the second synchroniser stage is seen by the meter
    assign dim.clk_level = r_q.dim_sync[1];

    logic       pwm_lvl;
    logic       pwm_rise;
    logic       pwm_fall;
    logic [7:0] target;

    assign pwm_lvl  = r_q.pwm_sync[1];
    assign pwm_rise = pwm_lvl && !r_q.pwm_prev;
    assign pwm_fall = !pwm_lvl && r_q.pwm_prev;

    always_comb begin
        logic [7:0] raw;
        raw = voltage_level_i;
        // RQ7 clocked mode source
        if (dim.mode == LDPS_MODE_CLOCKED) begin
            raw = dim.meas_level;
        end
        // RQ5 RQ11 floor at minimum
        if (raw < `LDPS_LVL_MIN) begin
            target = `LDPS_LVL_MIN;
        end else begin
            target = raw;
        end
    end

    always_comb begin
        r_d = r_q;
        r_d.pwm_sync = {r_q.pwm_sync[0], pwm_i};
        r_d.dim_sync = {r_q.dim_sync[0], analog_dim_input_i};
        r_d.pwm_prev = pwm_lvl;
        if (r_q.timer != '0) begin
            r_d.timer = r_q.timer - TW'(1);
        end
        case (r_q.state)
            LDPS_OFF: begin
                // RQ13 long low shutdown
                if (r_q.off_cnt != SW'(SHUTDOWN_CYC)) begin
                    r_d.off_cnt = r_q.off_cnt + SW'(1);
                end else begin
                    r_d.state = LDPS_SLEEP;
                end
                if (pwm_rise) begin
                    r_d.state = LDPS_PRE;
                end
            end
            LDPS_PRE: begin
                // RQ1 sinks wait for timer
                if (pwm_fall) begin
                    r_d.state = LDPS_POST;
                    // Elapsed part of the rise delay gates the sinks
                    r_d.gate  = pre_boost_time_i - r_q.timer;
                end else if (r_q.timer == '0) begin
                    r_d.state = LDPS_ON;
                end
            end
            LDPS_ON: begin
                // RQ12 sinks follow enable
                if (pwm_fall) begin
                    r_d.state = LDPS_POST;
                    r_d.gate  = '1;
                end
            end
            LDPS_POST: begin
                // RQ2 hold after fall
                if (pwm_rise) begin
                    r_d.state = LDPS_PRE;
                end else if (r_q.timer == '0) begin
                    r_d.state = LDPS_OFF;
                end
            end
            LDPS_SLEEP: begin
                // Wake needs a fresh rising edge
                if (pwm_rise) begin
                    r_d.state = LDPS_PRE;
                end
            end
            default: begin
                r_d.state = LDPS_OFF;
            end
        endcase
        // RQ3 RQ16 full delay per edge
        if (pwm_rise || pwm_fall) begin
            r_d.timer = pre_boost_time_i;
        end
        if (r_d.state != LDPS_OFF) begin
            r_d.off_cnt = '0;
        end

        // Outputs follow the next state so they register together
        r_d.boost = 1'b0;
        r_d.sink  = 1'b0;
        r_d.sleep = 1'b0;
        case (r_d.state)
            LDPS_PRE: begin
                r_d.boost = 1'b1;
            end
            LDPS_ON: begin
                r_d.boost = 1'b1;
                r_d.sink  = 1'b1;
            end
            LDPS_POST: begin
                // RQ1 RQ2 short pulse sinks
                // A pulse shorter than the delay still lights for its width
                r_d.boost = 1'b1;
                r_d.sink  = (r_d.timer <= r_d.gate);
            end
            LDPS_SLEEP: begin
                r_d.sleep = 1'b1;
            end
            default: begin
                r_d.sleep = 1'b0;
            end
        endcase

        // RQ15 gradual level ramp
        // Single steps keep the sink current free of jumps
        if (r_q.slew_cnt != '0) begin
            r_d.slew_cnt = r_q.slew_cnt - LW'(1);
        end else begin
            r_d.slew_cnt = LW'(`LDPS_SLEW_CYC - 1);
            if (r_q.level < target) begin
                r_d.level = r_q.level + 8'h01;
            end else if (r_q.level > target) begin
                r_d.level = r_q.level - 8'h01;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            r_q       <= '0;
            r_q.state <= LDPS_OFF;
            r_q.level <= `LDPS_LVL_RESET;
        end else begin
            r_q <= r_d;
        end
    end

    assign boost_en_o         = r_q.boost;
    assign sink_en_o          = r_q.sink;
    assign shutdown_o         = r_q.sleep;
    assign clocked_dim_mode_o = (dim.mode == LDPS_MODE_CLOCKED);
    assign current_level_o    = r_q.level;

endmodule : ldps_top

//--- sim/ldps_host.sv
module ldps_host (
    // Clock
    input  wire logic mclk_i,
    // Requests from the bench
    input  wire logic pwm_req_i,
    input  wire logic dim_run_i,
    // Dimming pins
    output logic      pwm_o,
    output logic      dim_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] low_q = 8'hC8;
    logic [7:0] ph_q  = 8'h00;

    initial pwm_o = 1'b0;
    initial dim_o = 1'b0;

    always @(posedge mclk_i) begin
        // min low 1us: an early rise waits out the guard
        pwm_o <= pwm_req_i && (pwm_o || low_q == 8'hC8);
        low_q <= pwm_o ? 8'h00 : low_q + 8'(low_q != 8'hC8);
        // high 170, low 30 of 200 cycles, 1 MHz
        ph_q  <= (!dim_run_i || ph_q == 8'hC7) ? 8'h00 : ph_q + 8'h01;
        // Idle pin is driven low while dim_run_i is low
        dim_o <= dim_run_i && ph_q < 8'hAA;
    end
endmodule : ldps_host

//--- sim/ldps_top_checker.sv
module ldps_checker
    import ldps_pkg::*;
#(
    parameter int TW           = 10,
    parameter int SHUTDOWN_CYC = 200,
    parameter int FALLBACK_CYC = 100
) (
    // Clock and reset
    input wire logic          mclk_i,
    input wire logic          reset_i,
    // Design inputs
    input wire logic          pwm_i,
    input wire logic          analog_dim_input_i,
    input wire logic [TW-1:0] pre_boost_time_i,
    input wire logic [7:0]    voltage_level_i,
    // Design outputs
    input wire logic          boost_en_o,
    input wire logic          sink_en_o,
    input wire logic          shutdown_o,
    input wire logic          clocked_dim_mode_o,
    input wire logic [7:0]    current_level_o
);
    logic [TW+1:0] pre_q;
    logic [23:0]   low_q;
    logic [15:0]   gap_q;
    logic          dim_q;

    // Counts restart on reset so no stale span survives it
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pre_q <= '0;
            low_q <= '0;
            gap_q <= '0;
            dim_q <= 1'b0;
        end else begin
            pre_q <= (boost_en_o && !sink_en_o) ? pre_q + 1'b1 : '0;
            low_q <= pwm_i ? '0 : low_q + 24'(~&low_q);
            gap_q <= (analog_dim_input_i != dim_q) ? '0 : gap_q + 16'(~&gap_q);
            dim_q <= analog_dim_input_i;
        end
    end

    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    boost_start_a: assert property (
        $rose(pwm_i) |-> ##[3:5] boost_en_o) else $error("boost late");
    sink_delay_a: assert property (
        $rose(sink_en_o) |-> pre_q >= {2'b00, pre_boost_time_i})
        else $error("sinks early");
    sink_boost_a: assert property (
        sink_en_o |-> boost_en_o) else $error("sinks without boost");
    fall_together_a: assert property (
        $fell(boost_en_o) |-> $fell(sink_en_o)) else $error("split fall");
    fall_hold_a: assert property (
        $fell(sink_en_o) |-> low_q >= 24'(pre_boost_time_i))
        else $error("hold short");
    sleep_off_a: assert property (
        shutdown_o |-> !boost_en_o && !sink_en_o) else $error("awake");
    sleep_time_a: assert property (
        $rose(shutdown_o) |-> low_q >= 24'(SHUTDOWN_CYC))
        else $error("sleep early");
    level_floor_a: assert property (
        current_level_o >= 8'h1A) else $error("level below floor");
    level_step_a: assert property (
        $changed(current_level_o) |->
        (current_level_o - $past(current_level_o) == 8'h01) ||
        ($past(current_level_o) - current_level_o == 8'h01))
        else $error("level jump");
    mode_enter_a: assert property (
        $rose(clocked_dim_mode_o) |-> gap_q < 16'h0008)
        else $error("mode without edge");
    mode_fallback_a: assert property (
        gap_q > 16'(FALLBACK_CYC + 10) |-> !clocked_dim_mode_o)
        else $error("no fallback");
endmodule : ldps_checker

bind ldps_top ldps_checker #(.TW(TW), .SHUTDOWN_CYC(SHUTDOWN_CYC),
    .FALLBACK_CYC(FALLBACK_CYC)) chk (.mclk_i(mclk_i), .reset_i(reset_i),
    .pwm_i(pwm_i), .analog_dim_input_i(analog_dim_input_i),
    .pre_boost_time_i(pre_boost_time_i), .voltage_level_i(voltage_level_i),
    .boost_en_o(boost_en_o), .sink_en_o(sink_en_o), .shutdown_o(shutdown_o),
    .clocked_dim_mode_o(clocked_dim_mode_o),
    .current_level_o(current_level_o));

//--- sim/test_led_dim_preboost_sequencer.sv
module test_led_dim_preboost_sequencer;
    import ldps_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic       mclk_i = 1'b0;
    logic       reset_i = 1'b1;
    logic       pwm_req = 1'b0;
    logic       dim_run = 1'b0;
    logic       pwm_i;
    logic       dim_pin;
    logic [9:0] pre_boost_time_i = 10'h000;
    logic [7:0] voltage_level_i = 8'h00;
    logic       boost_en_o, sink_en_o, shutdown_o, clocked_dim_mode_o;
    logic [7:0] current_level_o;
    int         err_total = 0;
    int         checked = 0;
    int         b, s;

    initial forever #2.5 mclk_i = ~mclk_i;

    ldps_host host (.mclk_i(mclk_i), .pwm_req_i(pwm_req),
        .dim_run_i(dim_run), .pwm_o(pwm_i), .dim_o(dim_pin));

    // Short sleep and fallback counts keep the run brief
    ldps_top #(.SHUTDOWN_CYC(4000), .FALLBACK_CYC(400)) DUT (
        .mclk_i(mclk_i), .reset_i(reset_i), .pwm_i(pwm_i),
        .analog_dim_input_i(dim_pin), .pre_boost_time_i(pre_boost_time_i),
        .voltage_level_i(voltage_level_i), .boost_en_o(boost_en_o),
        .sink_en_o(sink_en_o), .shutdown_o(shutdown_o),
        .clocked_dim_mode_o(clocked_dim_mode_o),
        .current_level_o(current_level_o));

    task automatic check(input logic [31:0] got, lo, hi);
        checked++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            err_total++;
            $display("[ERR] %0t got %h want %h..%h", $time, got, lo, hi);
        end
    endtask : check

    // Pulse the pin and count boost and sink cycles
    task automatic pulse(input int t, input int hi);
        b = 0;
        s = 0;
        @(posedge mclk_i);
        pre_boost_time_i <= 10'(t);
        for (int i = 0; i < hi + 1500; i++) begin
            @(posedge mclk_i);
            pwm_req <= (i < hi - 1);
            b += int'(boost_en_o === 1'b1);
            s += int'(sink_en_o === 1'b1);
        end
    endtask : pulse

    task automatic t_reset;
        check(current_level_o, 8'h1A, 8'h1A);
        check({shutdown_o, boost_en_o, clocked_dim_mode_o}, 0, 0);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_edges;
        pulse(5, 40);
        check(b - s, 6, 7);
        check(s, 38, 42);
        pulse(0, 40);
        check(b - s, 1, 2);
        $display("t_edges done");
    endtask : t_edges

    task automatic t_retrigger;
        pulse(600, 40);
        check(b - s, 600, 602);
        check(s, 38, 42);
        check(b, 639, 641);
        $display("t_retrigger done");
    endtask : t_retrigger

    task automatic t_sleep;
        repeat (2500) @(posedge mclk_i);
        check(shutdown_o, 0, 0);
        repeat (1000) @(posedge mclk_i);
        check(shutdown_o, 1, 1);
        pwm_req <= 1'b1;
        repeat (10) @(posedge mclk_i);
        check({shutdown_o, boost_en_o}, 1, 1);
        $display("t_sleep done");
    endtask : t_sleep

    task automatic t_dim;
        dim_run <= 1'b1;
        repeat (400) @(posedge mclk_i);
        check(clocked_dim_mode_o, 1, 1);
        repeat (3200) @(posedge mclk_i);
        check(current_level_o, 8'h1B, 8'h20);
        repeat (9600) @(posedge mclk_i);
        check(current_level_o, 8'h26, 8'h26);
        dim_run <= 1'b0;
        repeat (450) @(posedge mclk_i);
        check(clocked_dim_mode_o, 0, 0);
        repeat (11200) @(posedge mclk_i);
        check(current_level_o, 8'h1A, 8'h1A);
        voltage_level_i <= 8'h1C;
        repeat (2000) @(posedge mclk_i);
        check(current_level_o, 8'h1C, 8'h1C);
        $display("t_dim done");
    endtask : t_dim

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    initial begin
        #(60000 * 5);
        err_total++;
        give_verdict();
    end

    initial begin
        repeat (12) @(posedge mclk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        t_reset();
        t_edges();
        t_retrigger();
        t_sleep();
        t_dim();
        give_verdict();
    end
endmodule : test_led_dim_preboost_sequencer
